/* hw/dpr_divider.sv */
// Purpose: Sequential restoring divider for mean values.
// Assumes: start is a one-cycle pulse while idle.
// Notes: Divisor zero yields quotient zero; one bit per cycle.
`timescale 1ns/1ps
module dpr_divider (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic start,
   input wire logic [dpr_pkg::ACC_W-1:0] dividend,
   input wire logic [dpr_pkg::CNT_W-1:0] divisor,
   output logic done,
   output logic [dpr_pkg::ACC_W-1:0] quotient
);
   import dpr_pkg::*;
   logic [ACC_W-1:0] quo_q;
   logic [CNT_W:0] rem_q;
   logic [CNT_W-1:0] dvs_q;
   logic [6:0] bit_q;
   logic busy_q;
   logic done_q;
   wire [CNT_W:0] rem_sh = {rem_q[CNT_W-1:0], quo_q[ACC_W-1]};
   wire rem_ge = rem_sh >= {1'b0, dvs_q};
   always_ff @(posedge clk_sys) begin
      done_q <= 1'b0;
      if (srst) begin
         quo_q <= '0;
         rem_q <= '0;
         dvs_q <= '0;
         bit_q <= '0;
         busy_q <= 1'b0;
      end else if (start) begin
         quo_q <= dividend;
         rem_q <= '0;
         dvs_q <= divisor;
         bit_q <= 7'(ACC_W);
         busy_q <= 1'b1;
      end else if (busy_q) begin
         rem_q <= rem_ge ? rem_sh - {1'b0, dvs_q} : rem_sh;
         quo_q <= {quo_q[ACC_W-2:0], rem_ge};
         bit_q <= bit_q - 7'h01;
         if (bit_q == 7'h01) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
         end
      end
   end
   assign done = done_q;
   assign quotient = (dvs_q == '0) ? '0 : quo_q;
endmodule : dpr_divider

/* hw/dpr_pkg.sv */
// Purpose: Shared constants and types of the demand peak recorder.
// Assumes: One sample strobe per second from the measurement front end.
// Notes: Parameter addresses are word indices of the device parameter list.
package dpr_pkg;
   localparam int unsigned CLK_NS = 4;
   localparam int unsigned SEC_NS = 1000000000;
   localparam int unsigned SEC_CYCLES = SEC_NS / CLK_NS;
   localparam int unsigned SEC_PER_MIN = 60;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned RD_W = 32;
   localparam int unsigned NVAR = 15;
   localparam int unsigned NRANK = 3;
   localparam int unsigned NREC = 4;
   localparam int unsigned NENT = 100;
   localparam int unsigned NQ = 16;
   localparam int unsigned SMP_W = 34;
   localparam int unsigned Q_W = 32;
   localparam int unsigned ACC_W = 56;
   localparam int unsigned CNT_W = 24;
   localparam int unsigned TS_W = 32;
   // Parameter list offsets
   localparam logic [15:0] AVG_PERIOD_OFF = 16'h00CE;
   localparam logic [15:0] SYNC_CAPTURE_OFF = 16'h00CF;
   localparam logic [15:0] INPUT1_SYNC_OFF = 16'h00D0;
   localparam logic [15:0] PEAK_CLEAR_OFF = 16'h01FA;
   localparam logic [15:0] REC_CFG_BASE = 16'h0300;
   localparam logic [15:0] REC_EN_OFF = 16'h0308;
   localparam logic [15:0] PEAK_BASE = 16'h0400;
   localparam logic [15:0] REC_MEM_BASE = 16'h1000;
   // Ranges and reset values
   localparam logic [15:0] AVG_PERIOD_MIN = 16'h012C;
   localparam logic [15:0] AVG_PERIOD_MAX = 16'h0E10;
   localparam logic [15:0] AVG_PERIOD_RST = 16'h0384;
   localparam logic [15:0] SYNC_CAPTURE_MIN = 16'h0001;
   localparam logic [15:0] SYNC_CAPTURE_MAX = 16'h0014;
   localparam logic [15:0] SYNC_CAPTURE_RST = 16'h000A;
   localparam logic [15:0] INPUT1_SYNC_MAX = 16'h0002;
   localparam logic [15:0] INPUT1_SYNC_RST = 16'h0000;
   localparam logic [15:0] REC_TB_MIN = 16'h0001;
   localparam logic [15:0] REC_TB_MAX = 16'h05A0;
   localparam logic [15:0] REC0_TB_RST = 16'h000F;
   localparam logic [15:0] REC1_TB_RST = 16'h003C;
   localparam logic [15:0] RECX_TB_RST = 16'h000F;
   localparam logic [3:0] REC0_Q_RST = 4'h0;
   localparam logic [3:0] REC1_Q_RST = 4'h1;
   localparam logic [3:0] REC_EN_RST = 4'h3;
   typedef enum logic [2:0] {
      DPR_S_IDLE = 3'b001,
      DPR_S_PDIV = 3'b010,
      DPR_S_RDIV = 3'b100
   } dpr_state_t;
endpackage : dpr_pkg

/* hw/dpr_recorder.sv */
// Purpose: Period mean peak recorder with three peaks per variable and a small recording store.
// Assumes: sample_valid pulses once per second with all phase quantities; din1_pin is asynchronous.
// Notes: One shared divider serves peak means first, then recording means.
`timescale 1ns/1ps
// Summary of operation
// - Averaging period comes from a parameter, 300 to 3600 s, default 900.
// - Period boundaries follow the internal second clock or digital input 1.
// - External sync uses a capture time of 1 to 20 s, default 10.
// - Input-1 field: 0 internal, 1 or 2 external; default 0.
// - Three largest period means with timestamps are kept for 15 variables.
// - Variables: phase currents, consumed/exported power per phase and total, apparent power.
// - Power samples split into positive and negative streams before averaging.
// - The power total is summed over phases first, then split by sign.
// - Writing the clear parameter from 0 to 1 wipes all stored peaks.
// - A recording time base below one minute is refused.
// - Up to four recordings, each holding 100 entries.
// - Each recording entry keeps mean, minimum and maximum of its interval.
// - Recording one defaults on with a 15 minute time base.
// - Recording two defaults on with a one hour time base.
module dpr_recorder #(
   parameter int unsigned SEC_CYCLES = dpr_pkg::SEC_CYCLES
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic din1_pin,
   input wire logic sample_valid,
   input wire logic [3*dpr_pkg::Q_W-1:0] cur_ph,
   input wire logic [3*dpr_pkg::Q_W-1:0] pwr_ph,
   input wire logic [3*dpr_pkg::Q_W-1:0] app_ph,
   input wire logic [dpr_pkg::NQ*dpr_pkg::Q_W-1:0] rec_qty,
   input wire logic par_we,
   input wire logic par_re,
   input wire logic [dpr_pkg::ADDR_W-1:0] par_addr,
   input wire logic [dpr_pkg::DATA_W-1:0] par_wdata,
   output logic [dpr_pkg::RD_W-1:0] par_rdata,
   output logic par_rvalid,
   output logic period_end,
   output logic peak_busy
);
   import dpr_pkg::*;

   function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      in_rng = (v >= lo) && (v <= hi);
   endfunction : in_rng

   function automatic logic [Q_W-1:0] pos_part(input logic signed [Q_W+1:0] v);
      pos_part = v[Q_W+1] ? '0 : v[Q_W-1:0];
   endfunction : pos_part

   function automatic logic [Q_W-1:0] neg_part(input logic signed [Q_W+1:0] v);
      logic signed [Q_W+1:0] n;
      n = -v;
      neg_part = v[Q_W+1] ? n[Q_W-1:0] : '0;
   endfunction : neg_part

   // Configuration registers
   logic [15:0] period_q, capture_q, sync_sel_q, clr_q;
   logic [15:0] rec_tb_q [NREC];
   logic [3:0] rec_sel_q [NREC];
   logic [3:0] rec_en_q;
   wire wr_period = par_we && par_addr == AVG_PERIOD_OFF && in_rng(par_wdata, AVG_PERIOD_MIN, AVG_PERIOD_MAX);
   wire wr_capture = par_we && par_addr == SYNC_CAPTURE_OFF && in_rng(par_wdata, SYNC_CAPTURE_MIN, SYNC_CAPTURE_MAX);
   wire wr_sel = par_we && par_addr == INPUT1_SYNC_OFF && par_wdata <= INPUT1_SYNC_MAX;
   wire wr_clr = par_we && par_addr == PEAK_CLEAR_OFF && par_wdata <= 16'h0001;
   wire peak_clr = wr_clr && par_wdata[0] && clr_q == 16'h0000;
   wire wr_rec_en = par_we && par_addr == REC_EN_OFF;
   wire in_rec_cfg = par_addr[15:3] == REC_CFG_BASE[15:3];
   wire [1:0] cfg_rec = par_addr[2:1];
   wire ext_sync = sync_sel_q != INPUT1_SYNC_RST;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         period_q <= AVG_PERIOD_RST;
         capture_q <= SYNC_CAPTURE_RST;
         sync_sel_q <= INPUT1_SYNC_RST;
         clr_q <= 16'h0000;
         rec_en_q <= REC_EN_RST;
         for (int i = 0; i < NREC; i++) begin
            rec_tb_q[i] <= (i == 0) ? REC0_TB_RST : (i == 1) ? REC1_TB_RST : RECX_TB_RST;
            rec_sel_q[i] <= (i == 1) ? REC1_Q_RST : REC0_Q_RST;
         end
      end else begin
         if (wr_period) period_q <= par_wdata;
         if (wr_capture) capture_q <= par_wdata;
         if (wr_sel) sync_sel_q <= par_wdata;
         if (wr_clr) clr_q <= par_wdata;
         if (wr_rec_en) rec_en_q <= par_wdata[NREC-1:0];
         if (par_we && in_rec_cfg && !par_addr[0] && in_rng(par_wdata, REC_TB_MIN, REC_TB_MAX))
            rec_tb_q[cfg_rec] <= par_wdata;
         if (par_we && in_rec_cfg && par_addr[0]) rec_sel_q[cfg_rec] <= par_wdata[3:0];
      end
   end

   // Input 1 synchroniser and second base; stage one feeds stage two only
   logic din_s1_q, din_s2_q, din_s3_q;
   logic [31:0] cyc_q;
   logic sec_tick_q;
   logic [TS_W-1:0] tstamp_q;
   logic [15:0] elapsed_q;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         din_s1_q <= 1'b0;
         din_s2_q <= 1'b0;
         din_s3_q <= 1'b0;
         cyc_q <= '0;
         sec_tick_q <= 1'b0;
         tstamp_q <= '0;
      end else begin
         din_s1_q <= din1_pin;
         din_s2_q <= din_s1_q;
         din_s3_q <= din_s2_q;
         sec_tick_q <= cyc_q == 32'(SEC_CYCLES - 1);
         cyc_q <= (cyc_q == 32'(SEC_CYCLES - 1)) ? '0 : cyc_q + 32'h1;
         if (sec_tick_q) tstamp_q <= tstamp_q + 32'h1;
      end
   end

   // Period boundary: internal end, or accepted pulse, or timeout past the capture window
   wire [16:0] el_next = {1'b0, elapsed_q} + 17'h1;
   wire [16:0] el_cap = {1'b0, elapsed_q} + {1'b0, capture_q};
   wire [16:0] per_cap = {1'b0, period_q} + {1'b0, capture_q};
   wire din_rise = din_s2_q && !din_s3_q;
   wire int_end = sec_tick_q && el_next >= {1'b0, period_q};
   wire ext_hit = din_rise && el_cap >= {1'b0, period_q};
   wire ext_late = sec_tick_q && el_next >= per_cap;
   wire boundary = ext_sync ? (ext_hit || ext_late) : int_end;
   logic boundary_q;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         elapsed_q <= '0;
         boundary_q <= 1'b0;
      end else begin
         boundary_q <= boundary;
         if (boundary) elapsed_q <= '0;
         else if (sec_tick_q) elapsed_q <= elapsed_q + 16'h1;
      end
   end

   // Tracked variables, power split by sign before averaging
   logic [SMP_W-1:0] smp [NVAR];
   logic signed [Q_W+1:0] p_ph [3];
   wire signed [Q_W+1:0] p_tot = p_ph[0] + p_ph[1] + p_ph[2];
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_ph
         assign p_ph[g] = (Q_W+2)'($signed(pwr_ph[g*Q_W +: Q_W]));
         assign smp[g] = SMP_W'(cur_ph[g*Q_W +: Q_W]);
         assign smp[3+g] = SMP_W'(pos_part(p_ph[g]));
         assign smp[6+g] = SMP_W'(neg_part(p_ph[g]));
         assign smp[11+g] = SMP_W'(app_ph[g*Q_W +: Q_W]);
      end
   endgenerate
   assign smp[9] = p_tot[Q_W+1] ? '0 : SMP_W'(p_tot);
   assign smp[10] = p_tot[Q_W+1] ? SMP_W'(-p_tot) : '0;
   assign smp[14] = SMP_W'(app_ph[Q_W-1:0]) + SMP_W'(app_ph[2*Q_W-1:Q_W]) + SMP_W'(app_ph[3*Q_W-1:2*Q_W]);

   // Period accumulators with a snapshot taken at each boundary
   logic [ACC_W-1:0] acc_q [NVAR];
   logic [ACC_W-1:0] snap_q [NVAR];
   logic [CNT_W-1:0] cnt_q, snap_cnt_q;
   generate
      for (g = 0; g < NVAR; g++) begin : g_acc
         always_ff @(posedge clk_sys) begin
            if (srst) begin
               acc_q[g] <= '0;
               snap_q[g] <= '0;
            end else if (boundary) begin
               snap_q[g] <= acc_q[g];
               acc_q[g] <= sample_valid ? ACC_W'(smp[g]) : '0;
            end else if (sample_valid) begin
               acc_q[g] <= acc_q[g] + ACC_W'(smp[g]);
            end
         end
      end
   endgenerate
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt_q <= '0;
         snap_cnt_q <= '0;
      end else if (boundary) begin
         snap_cnt_q <= cnt_q;
         cnt_q <= sample_valid ? CNT_W'(1) : '0;
      end else if (sample_valid) begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   // Recording interval accumulators
   logic signed [ACC_W-1:0] racc_q [NREC];
   logic signed [Q_W-1:0] rmin_q [NREC], rmax_q [NREC];
   logic [CNT_W-1:0] rcnt_q [NREC];
   logic signed [ACC_W-1:0] rs_sum_q [NREC];
   logic signed [Q_W-1:0] rs_min_q [NREC], rs_max_q [NREC];
   logic [CNT_W-1:0] rs_cnt_q [NREC];
   logic [5:0] rsec_q [NREC];
   logic [15:0] rminute_q [NREC];
   logic [NREC-1:0] rpend_q;
   logic [NREC-1:0] rtake;
   generate
      for (g = 0; g < NREC; g++) begin : g_rec
         wire signed [Q_W-1:0] q = rec_qty[rec_sel_q[g]*Q_W +: Q_W];
         wire min_edge = rsec_q[g] == 6'(SEC_PER_MIN - 1);
         wire rend = rec_en_q[g] && sec_tick_q && min_edge && rminute_q[g] + 16'h1 >= rec_tb_q[g];
         wire first = rcnt_q[g] == '0;
         always_ff @(posedge clk_sys) begin
            if (srst || !rec_en_q[g]) begin
               racc_q[g] <= '0;
               rcnt_q[g] <= '0;
               rmin_q[g] <= '0;
               rmax_q[g] <= '0;
               rsec_q[g] <= '0;
               rminute_q[g] <= '0;
               rpend_q[g] <= 1'b0;
            end else begin
               if (sec_tick_q) rsec_q[g] <= min_edge ? 6'h00 : rsec_q[g] + 6'h01;
               if (rend) begin
                  rminute_q[g] <= '0;
                  rs_sum_q[g] <= racc_q[g];
                  rs_cnt_q[g] <= rcnt_q[g];
                  rs_min_q[g] <= rmin_q[g];
                  rs_max_q[g] <= rmax_q[g];
                  racc_q[g] <= '0;
                  rcnt_q[g] <= '0;
               end else begin
                  if (sec_tick_q && min_edge) rminute_q[g] <= rminute_q[g] + 16'h1;
                  if (sample_valid) begin
                     racc_q[g] <= racc_q[g] + ACC_W'(q);
                     rcnt_q[g] <= rcnt_q[g] + CNT_W'(1);
                     if (first || q < rmin_q[g]) rmin_q[g] <= q;
                     if (first || q > rmax_q[g]) rmax_q[g] <= q;
                  end
               end
               // A new interval end wins over the take by the sequencer
               rpend_q[g] <= rend || (rpend_q[g] && !rtake[g]);
            end
         end
      end
   endgenerate

   // Sequencer sharing one divider
   dpr_state_t state_q;
   logic ppend_q;
   logic [3:0] vidx_q;
   logic [1:0] ridx_q;
   logic div_start_q;
   logic div_done;
   logic [ACC_W-1:0] div_quo;
   wire [1:0] rpick = rpend_q[0] ? 2'd0 : rpend_q[1] ? 2'd1 : rpend_q[2] ? 2'd2 : 2'd3;
   wire rgo = state_q == DPR_S_IDLE && !ppend_q && rpend_q != '0;
   generate
      for (g = 0; g < NREC; g++) begin : g_take
         assign rtake[g] = rgo && rpick == 2'(g);
      end
   endgenerate
   wire signed [ACC_W-1:0] rsum = rs_sum_q[ridx_q];
   wire [ACC_W-1:0] rmag = rsum[ACC_W-1] ? ACC_W'(-rsum) : ACC_W'(rsum);
   wire [ACC_W-1:0] div_dvd = (state_q == DPR_S_RDIV) ? rmag : snap_q[vidx_q];
   wire [CNT_W-1:0] div_dvs = (state_q == DPR_S_RDIV) ? rs_cnt_q[ridx_q] : snap_cnt_q;
   wire [ACC_W-1:0] rneg = -div_quo;
   wire [Q_W-1:0] rmean = rsum[ACC_W-1] ? rneg[Q_W-1:0] : div_quo[Q_W-1:0];

   dpr_divider u_div (
      .clk_sys(clk_sys),
      .srst(srst),
      .start(div_start_q),
      .dividend(div_dvd),
      .divisor(div_dvs),
      .done(div_done),
      .quotient(div_quo)
   );

   wire pdone = state_q == DPR_S_PDIV && div_done;
   wire last_var = vidx_q == 4'(NVAR - 1);
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_q <= DPR_S_IDLE;
         ppend_q <= 1'b0;
         vidx_q <= '0;
         ridx_q <= '0;
         div_start_q <= 1'b0;
      end else begin
         div_start_q <= 1'b0;
         ppend_q <= boundary || (ppend_q && state_q != DPR_S_IDLE);
         unique case (state_q)
            DPR_S_IDLE: begin
               if (ppend_q) begin
                  state_q <= DPR_S_PDIV;
                  vidx_q <= '0;
                  div_start_q <= 1'b1;
               end else if (rgo) begin
                  state_q <= DPR_S_RDIV;
                  ridx_q <= rpick;
                  div_start_q <= 1'b1;
               end
            end
            DPR_S_PDIV: begin
               if (div_done) begin
                  if (last_var) begin
                     state_q <= DPR_S_IDLE;
                  end else begin
                     vidx_q <= vidx_q + 4'h1;
                     div_start_q <= 1'b1;
                  end
               end
            end
            DPR_S_RDIV: begin
               if (div_done) state_q <= DPR_S_IDLE;
            end
         endcase
      end
   end

   // Peak store: three means per variable, descending, with timestamps
   logic [SMP_W-1:0] pk_val_q [NVAR][NRANK];
   logic [TS_W-1:0] pk_ts_q [NVAR][NRANK];
   wire [SMP_W-1:0] mean_p = div_quo[SMP_W-1:0];
   generate
      for (g = 0; g < NVAR; g++) begin : g_peak
         wire ins = pdone && vidx_q == 4'(g);
         wire gt0 = mean_p > pk_val_q[g][0];
         wire gt1 = mean_p > pk_val_q[g][1];
         wire gt2 = mean_p > pk_val_q[g][2];
         always_ff @(posedge clk_sys) begin
            if (srst || peak_clr) begin
               for (int r = 0; r < NRANK; r++) begin
                  pk_val_q[g][r] <= '0;
                  pk_ts_q[g][r] <= '0;
               end
            end else if (ins) begin
               if (gt0) begin
                  pk_val_q[g][2] <= pk_val_q[g][1];
                  pk_ts_q[g][2] <= pk_ts_q[g][1];
                  pk_val_q[g][1] <= pk_val_q[g][0];
                  pk_ts_q[g][1] <= pk_ts_q[g][0];
                  pk_val_q[g][0] <= mean_p;
                  pk_ts_q[g][0] <= tstamp_q;
               end else if (gt1) begin
                  pk_val_q[g][2] <= pk_val_q[g][1];
                  pk_ts_q[g][2] <= pk_ts_q[g][1];
                  pk_val_q[g][1] <= mean_p;
                  pk_ts_q[g][1] <= tstamp_q;
               end else if (gt2) begin
                  pk_val_q[g][2] <= mean_p;
                  pk_ts_q[g][2] <= tstamp_q;
               end
            end
         end
      end
   endgenerate

   // Recording store, circular per recording
   logic [3*Q_W-1:0] rec_mem_q [NREC][NENT];
   logic [6:0] wptr_q [NREC];
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < NREC; i++) wptr_q[i] <= '0;
      end else if (state_q == DPR_S_RDIV && div_done) begin
         rec_mem_q[ridx_q][wptr_q[ridx_q]] <= {rmean, rs_min_q[ridx_q], rs_max_q[ridx_q]};
         wptr_q[ridx_q] <= (wptr_q[ridx_q] == 7'(NENT - 1)) ? 7'h00 : wptr_q[ridx_q] + 7'h01;
      end
   end

   // Parameter read decode
   wire [15:0] pk_off = par_addr - PEAK_BASE;
   wire in_peak = par_addr >= PEAK_BASE && pk_off < 16'(NVAR * 8) && pk_off[2:1] != 2'b11;
   wire [3:0] pk_v = pk_off[6:3];
   wire [1:0] pk_r = pk_off[2:1];
   wire [15:0] rm_off = par_addr - REC_MEM_BASE;
   wire [1:0] rm_r = rm_off[10:9];
   wire [6:0] rm_i = rm_off[8:2];
   wire in_rmem = par_addr >= REC_MEM_BASE && rm_off < 16'(NREC * 512) && rm_i < 7'(NENT) && rm_off[1:0] != 2'b11;
   wire [3*Q_W-1:0] rm_word = rec_mem_q[rm_r][rm_i];
   logic [RD_W-1:0] rd_d;
   always_comb begin
      rd_d = '0;
      if (par_addr == AVG_PERIOD_OFF) rd_d = RD_W'(period_q);
      else if (par_addr == SYNC_CAPTURE_OFF) rd_d = RD_W'(capture_q);
      else if (par_addr == INPUT1_SYNC_OFF) rd_d = RD_W'(sync_sel_q);
      else if (par_addr == PEAK_CLEAR_OFF) rd_d = RD_W'(clr_q);
      else if (par_addr == REC_EN_OFF) rd_d = RD_W'(rec_en_q);
      else if (in_rec_cfg) rd_d = par_addr[0] ? RD_W'(rec_sel_q[cfg_rec]) : RD_W'(rec_tb_q[cfg_rec]);
      else if (in_peak) rd_d = pk_off[0] ? pk_ts_q[pk_v][pk_r] : pk_val_q[pk_v][pk_r][RD_W-1:0];
      else if (in_rmem) rd_d = rm_word[(2 - rm_off[1:0]) * Q_W +: Q_W];
   end

   logic [RD_W-1:0] rdata_q;
   logic rvalid_q;
   logic busy_q;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdata_q <= '0;
         rvalid_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         rvalid_q <= par_re;
         if (par_re) rdata_q <= rd_d;
         busy_q <= ppend_q || state_q == DPR_S_PDIV;
      end
   end
   assign par_rdata = rdata_q;
   assign par_rvalid = rvalid_q;
   assign period_end = boundary_q;
   assign peak_busy = busy_q;
endmodule : dpr_recorder

/* testbench/demand_peak_recorder_tb.sv */
// Purpose: Self-checking bench for dpr_recorder.
// Assumes: A second shortened to 20 cycles.
// Notes: Phase inputs constant within each period, so a mean equals its sample.
`timescale 1ns/1ps
module demand_peak_recorder_tb;
   import dpr_pkg::*;
   localparam int unsigned SEC = 20;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic sample_valid = 1'b0;
   logic smp_en = 1'b1;
   logic par_we = 1'b0;
   logic par_re = 1'b0;
   logic fire = 1'b0;
   logic found = 1'b0;
   logic din1_pin, par_rvalid, period_end, peak_busy;
   logic [ADDR_W-1:0] par_addr = '0;
   logic [DATA_W-1:0] par_wdata = '0;
   logic [RD_W-1:0] par_rdata;
   logic [3*Q_W-1:0] cur_ph = {32'h12C, 32'hC8, 32'h64};
   logic [3*Q_W-1:0] pwr_ph = {32'hA, 32'hFFFFFFB0, 32'h32};
   logic [3*Q_W-1:0] app_ph = {32'hBB8, 32'h7D0, 32'h3E8};
   logic [15:0] exp_pk [15] = '{16'h64, 16'hC8, 16'h12C, 16'h32, 16'h0, 16'hA, 16'h0, 16'h50, 16'h0, 16'h0,
      16'h14, 16'h3E8, 16'h7D0, 16'hBB8, 16'h1770};
   logic [31:0] dflt [10] = '{32'h00CE0384, 32'h00CF000A, 32'h00D00000, 32'h01FA0000, 32'h0300000F,
      32'h0302003C, 32'h03010000, 32'h03030001, 32'h03080003, 32'h00070000};
   logic [47:0] tbl [12] = '{48'h00CE012B0384, 48'h00CE0E110384, 48'h00CE012C012C, 48'h00CF0000000A,
      48'h00CF0015000A, 48'h00CF00140014, 48'h00D000030000, 48'h00D000020002, 48'h00D000000000,
      48'h03000000000F, 48'h030000010001, 48'h01FA00020000};
   int n_fail = 0;
   int num_checks = 0;
   int tick = 0;
   int t0 = 0;
   dpr_recorder #(.SEC_CYCLES(SEC)) u_dpr_recorder (
      .clk_sys(clk_sys), .srst(srst), .din1_pin(din1_pin), .sample_valid(sample_valid),
      .cur_ph(cur_ph), .pwr_ph(pwr_ph), .app_ph(app_ph), .rec_qty({NQ{32'h100}}),
      .par_we(par_we), .par_re(par_re), .par_addr(par_addr), .par_wdata(par_wdata),
      .par_rdata(par_rdata), .par_rvalid(par_rvalid), .period_end(period_end), .peak_busy(peak_busy));
   dpr_sync_src u_dpr_sync_src (.clk_sys(clk_sys), .fire(fire), .din1_pin(din1_pin));
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   // Samples can be gated so none lands near a boundary whose inputs change
   always @(negedge clk_sys) begin
      tick <= tick + 1;
      sample_valid <= smp_en && (tick % SEC == 0);
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      par_we = 1'b1;
      par_addr = a;
      par_wdata = d;
      @(negedge clk_sys);
      par_we = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      @(negedge clk_sys);
      par_re = 1'b1;
      par_addr = a;
      @(negedge clk_sys);
      par_re = 1'b0;
      check(par_rdata, exp);
   endtask : rd
   task automatic wait_end(input int lim);
      found = 1'b0;
      for (int i = 0; i < lim && !found; i++) begin
         @(negedge clk_sys);
         found = period_end;
      end
      t0 = tick;
   endtask : wait_end
   task automatic settle();
      repeat (4) @(negedge clk_sys);
      for (int i = 0; i < 2000 && peak_busy !== 1'b0; i++) @(negedge clk_sys);
   endtask : settle
   task automatic pulse_at(input int t);
      while (tick < t) @(negedge clk_sys);
      fire = 1'b1;
      @(negedge clk_sys);
      fire = 1'b0;
   endtask : pulse_at
   task automatic conclude();
      $display("checks=%0d failures=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (30000) @(posedge clk_sys);
      n_fail++;
      conclude();
   end
   initial begin
      repeat (8) @(negedge clk_sys);
      srst = 1'b0;
      foreach (dflt[i]) rd(dflt[i][31:16], {16'h0, dflt[i][15:0]});
      foreach (tbl[i]) begin
         wr(tbl[i][47:32], tbl[i][31:16]);
         rd(tbl[i][47:32], {16'h0, tbl[i][15:0]});
      end
      wait_end(7000);
      check({31'h0, found}, 32'h1);
      settle();
      foreach (exp_pk[v]) rd(16'(PEAK_BASE + v * 8), {16'h0, exp_pk[v]});
      rd(REC_MEM_BASE, 32'h100);
      rd(16'(REC_MEM_BASE + 1), 32'h100);
      rd(16'(REC_MEM_BASE + 2), 32'h100);
      while (tick < t0 + 5940) @(negedge clk_sys);
      smp_en = 1'b0;
      wait_end(300);
      check({31'h0, found}, 32'h1);
      cur_ph[31:0] = 32'h96;
      smp_en = 1'b1;
      settle();
      wr(INPUT1_SYNC_OFF, 16'h1);
      pulse_at(t0 + 100 * SEC);
      wait_end(20);
      check({31'h0, found}, 32'h0);
      // t0 restarts at each wait_end; this lands inside the capture window
      pulse_at(t0 + 185 * SEC);
      wait_end(10);
      check({31'h0, found}, 32'h1);
      settle();
      rd(PEAK_BASE, 32'h96);
      rd(16'(PEAK_BASE + 2), 32'h64);
      wr(PEAK_CLEAR_OFF, 16'h1);
      rd(PEAK_BASE, 32'h0);
      rd(16'(PEAK_BASE + 1), 32'h0);
      rd(PEAK_CLEAR_OFF, 32'h1);
      conclude();
   end
endmodule : demand_peak_recorder_tb

/* testbench/dpr_recorder_sva.sv */
// Purpose: Port assertions for dpr_recorder.
// Assumes: One clock domain, srst synchronous.
// Notes: Read range checks also catch refused writes.
`timescale 1ns/1ps
module dpr_recorder_sva #(
   parameter int unsigned SEC_CYCLES = 20
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic par_re,
   input wire logic [dpr_pkg::ADDR_W-1:0] par_addr,
   input wire logic [dpr_pkg::RD_W-1:0] par_rdata,
   input wire logic par_rvalid,
   input wire logic period_end,
   input wire logic peak_busy
);
   import dpr_pkg::*;
   logic [31:0] gap_q;
   logic [11:0] busy_q;
   always_ff @(posedge clk_sys) begin
      gap_q <= (srst || period_end) ? 32'h0 : gap_q + 32'h1;
      busy_q <= (srst || !peak_busy) ? 12'h0 : busy_q + 12'h1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   a_read_answer: assert property (par_re |=> par_rvalid)
      else $error("read got no answer");
   a_answer_cause: assert property (par_rvalid |-> $past(par_re))
      else $error("answer without read");
   a_period_range: assert property (par_re && par_addr == AVG_PERIOD_OFF |=>
      par_rdata >= AVG_PERIOD_MIN && par_rdata <= AVG_PERIOD_MAX) else $error("period out of range");
   a_capture_range: assert property (par_re && par_addr == SYNC_CAPTURE_OFF |=>
      par_rdata >= SYNC_CAPTURE_MIN && par_rdata <= SYNC_CAPTURE_MAX) else $error("capture out of range");
   a_sync_range: assert property (par_re && par_addr == INPUT1_SYNC_OFF |=> par_rdata <= INPUT1_SYNC_MAX)
      else $error("sync select out of range");
   a_clear_range: assert property (par_re && par_addr == PEAK_CLEAR_OFF |=> par_rdata <= 32'h1)
      else $error("clear value out of range");
   a_timebase_floor: assert property (par_re && par_addr inside {16'h0300, 16'h0302, 16'h0304, 16'h0306}
      |=> par_rdata >= REC_TB_MIN) else $error("time base below floor");
   a_period_spacing: assert property (period_end |-> gap_q >= 279 * SEC_CYCLES)
      else $error("period too short");
   a_end_pulse: assert property (period_end |=> !period_end)
      else $error("period end longer than one cycle");
   a_busy_follows: assert property (period_end |-> ##[0:1] peak_busy)
      else $error("peak update not started");
   a_busy_bounded: assert property (peak_busy |-> busy_q < 12'h7D0)
      else $error("peak update too long");
   cover property (period_end);
   cover property ($fell(peak_busy));
   cover property (par_rvalid);
endmodule : dpr_recorder_sva
bind dpr_recorder dpr_recorder_sva #(.SEC_CYCLES(SEC_CYCLES)) u_dpr_recorder_sva (
   .clk_sys(clk_sys), .srst(srst), .par_re(par_re), .par_addr(par_addr), .par_rdata(par_rdata),
   .par_rvalid(par_rvalid), .period_end(period_end), .peak_busy(peak_busy));

/* testbench/dpr_sync_src.sv */
// Purpose: Sync pulse source on digital input 1.
// Assumes: fire is a one-cycle request.
// Notes: Line idles low between pulses.
`timescale 1ns/1ps
module dpr_sync_src (
   input wire logic clk_sys,
   input wire logic fire,
   output logic din1_pin
);
   logic [7:0] width_q = 8'h0;
   always_ff @(posedge clk_sys) begin
      width_q <= fire ? 8'h28 : (width_q != 8'h0 ? width_q - 8'h1 : 8'h0);
   end
   assign din1_pin = width_q != 8'h0;
endmodule : dpr_sync_src
